// ### logic/mprs_pkg.sv
package mprs_pkg;

	// ***************************************************************
	// Timing
	// ***************************************************************
	localparam int CLK_MHZ = 125;
	localparam int SUPPLY_RAMP_MS = 300;
	localparam int SUPPLY_RAMP_CYC = SUPPLY_RAMP_MS * 1000 * CLK_MHZ;
	localparam int SWITCH_ON_MIN_US = 1000;
	localparam int WAKE_MIN_US = 1000;
	localparam int RESET_MIN_US = 100;
	localparam int SWITCH_ON_MIN_CYC = SWITCH_ON_MIN_US * CLK_MHZ;
	localparam int WAKE_MIN_CYC = WAKE_MIN_US * CLK_MHZ;
	localparam int RESET_MIN_CYC = RESET_MIN_US * CLK_MHZ;
	localparam int CNT_W = 32;

	// ***************************************************************
	// Command codes
	// ***************************************************************
	localparam logic [7:0] FUNC_FAST_OFF = 8'h0a;
	localparam logic [7:0] FUNC_REBOOT = 8'h10;

	typedef enum logic [2:0] {
		MPRS_OFF,
		MPRS_ON,
		MPRS_SLEEP,
		MPRS_SAVE,
		MPRS_DETACH,
		MPRS_REBOOT
	} mprs_state_e;

	typedef struct packed {
		logic graceful_poweroff_cmd;
		logic func_valid;
		logic [7:0] func_code;
		logic fast_off_gpio;
		logic temp_supervisor_cmd;
		logic temp_danger;
		logic sleep_req;
	} mprs_cmd_s;

	typedef struct packed {
		logic save_req;
		logic detach_req;
		logic core_on;
		logic v_int_en;
		logic sleeping;
	} mprs_stat_s;

endpackage

// ### logic/mprs_low_timer.sv
`timescale 1ns/10ps
module mprs_low_timer #(
	parameter int MIN_CYC = 1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic level_n,
	output logic hit
);
	logic [31:0] cnt;
	logic [31:0] next_cnt;
	logic next_hit;

	always_comb begin
		next_cnt = cnt;
		next_hit = 1'b0;
		if (level_n) begin
			next_cnt = '0;
		end else if (cnt < 32'(MIN_CYC)) begin
			next_cnt = cnt + 32'h1;
			next_hit = (cnt + 32'h1) == 32'(MIN_CYC);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
			hit <= 1'b0;
		end else begin
			cnt <= next_cnt;
			hit <= next_hit;
		end
	end
endmodule

// ### logic/mprs_sequencer.sv
`timescale 1ns/10ps
// Operation
// - Supply edge with fast ramp switches on.
// - Held-low switch-on input powers on.
// - Held-low switch-on wakes from deep sleep.
// - Graceful off saves, detaches, then off.
// - Code ten: save, no detach, off.
// - Fast-off input toggle: save, then off.
// - Ordered low pulses: abrupt emergency shutdown.
// - Enabled supervisor danger forces shutdown.
// - Code sixteen: save, detach, reboot.
// - Valid reset pulse: abrupt reboot.
// - Interface supply on in every state except off and sleep.
module mprs_sequencer #(
	parameter int SWITCH_ON_CYC = mprs_pkg::SWITCH_ON_MIN_CYC,
	parameter int WAKE_CYC = mprs_pkg::WAKE_MIN_CYC,
	parameter int RESET_CYC = mprs_pkg::RESET_MIN_CYC,
	parameter int RAMP_CYC = mprs_pkg::SUPPLY_RAMP_CYC,
	parameter bit EDGE_START = 1'b1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic supply_low,
	input wire logic supply_valid,
	input wire logic switch_on_request_n,
	input wire logic reset_request_n,
	input wire mprs_pkg::mprs_cmd_s cmd,
	input wire logic save_done,
	input wire logic detach_done,
	output mprs_pkg::mprs_stat_s stat,
	output mprs_pkg::mprs_state_e state
);
	// ***************************************************************
	// Pulse timers
	// ***************************************************************
	logic on_hit;
	logic wake_hit;
	logic rst_hit;

	mprs_low_timer #(.MIN_CYC(SWITCH_ON_CYC)) u_on (
		.mclk(mclk),
		.rst_n(rst_n),
		.level_n(switch_on_request_n),
		.hit(on_hit)
	);
	mprs_low_timer #(.MIN_CYC(WAKE_CYC)) u_wake (
		.mclk(mclk),
		.rst_n(rst_n),
		.level_n(switch_on_request_n),
		.hit(wake_hit)
	);
	mprs_low_timer #(.MIN_CYC(RESET_CYC)) u_rst (
		.mclk(mclk),
		.rst_n(rst_n),
		.level_n(reset_request_n),
		.hit(rst_hit)
	);

	// ***************************************************************
	// Supply ramp and event capture
	// ***************************************************************
	logic ramp_armed;
	logic next_ramp_armed;
	logic [31:0] ramp_cnt;
	logic [31:0] next_ramp_cnt;
	logic gpio_q;
	logic on_seen;
	logic next_on_seen;
	logic edge_hit;

	// The ramp is timed from the moment the supply leaves the low band.
	always_comb begin
		next_ramp_armed = ramp_armed;
		next_ramp_cnt = ramp_cnt;
		edge_hit = 1'b0;
		if (supply_low) begin
			next_ramp_armed = 1'b1;
			next_ramp_cnt = '0;
		end else if (ramp_armed) begin
			if (supply_valid) begin
				edge_hit = EDGE_START;
				next_ramp_armed = 1'b0;
			end else if (ramp_cnt >= 32'(RAMP_CYC)) begin
				next_ramp_armed = 1'b0;
			end else begin
				next_ramp_cnt = ramp_cnt + 32'h1;
			end
		end
		// A valid switch-on width is kept while the reset pin is low, so
		// the ordered pin sequence is told apart from a plain reset.
		// Both pins high ends the sequence, so a later reset just reboots.
		next_on_seen = on_seen;
		if (on_hit) begin
			next_on_seen = 1'b1;
		end else if (switch_on_request_n && !reset_request_n) begin
			next_on_seen = on_seen;
		end else if (reset_request_n && switch_on_request_n) begin
			next_on_seen = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ramp_armed <= 1'b0;
			ramp_cnt <= '0;
			gpio_q <= 1'b0;
			on_seen <= 1'b0;
		end else begin
			ramp_armed <= next_ramp_armed;
			ramp_cnt <= next_ramp_cnt;
			gpio_q <= cmd.fast_off_gpio;
			on_seen <= next_on_seen;
		end
	end

	// ***************************************************************
	// Power state machine
	// ***************************************************************
	mprs_pkg::mprs_state_e next_state;
	logic detach_pend;
	logic next_detach_pend;
	logic reboot_pend;
	logic next_reboot_pend;
	mprs_pkg::mprs_stat_s next_stat;
	logic gpio_tog;

	assign gpio_tog = cmd.fast_off_gpio ^ gpio_q;

	// Reset-pin and danger paths win over software commands: a held pin must never
	// be blocked by a slow save that the host can no longer see.
	always_comb begin
		next_state = state;
		next_detach_pend = detach_pend;
		next_reboot_pend = reboot_pend;
		unique case (state)
			mprs_pkg::MPRS_OFF: begin
				if (supply_valid && (on_hit || edge_hit)) begin
					next_state = mprs_pkg::MPRS_ON;
				end
			end
			mprs_pkg::MPRS_SLEEP: begin
				if (wake_hit) begin
					next_state = mprs_pkg::MPRS_ON;
				end
			end
			default: begin
				if (rst_hit && on_seen) begin
					next_state = mprs_pkg::MPRS_OFF;
				end else if (rst_hit) begin
					next_state = mprs_pkg::MPRS_REBOOT;
				// The enable is used as it stands: a delayed copy would let
				// a danger reading slip by in the cycle after enabling.
				end else if (cmd.temp_supervisor_cmd && cmd.temp_danger) begin
					next_state = mprs_pkg::MPRS_OFF;
				end else if (state == mprs_pkg::MPRS_ON) begin
					if (cmd.graceful_poweroff_cmd) begin
						next_state = mprs_pkg::MPRS_SAVE;
						next_detach_pend = 1'b1;
						next_reboot_pend = 1'b0;
					end else if (cmd.func_valid &&
							cmd.func_code == mprs_pkg::FUNC_FAST_OFF) begin
						next_state = mprs_pkg::MPRS_SAVE;
						next_detach_pend = 1'b0;
						next_reboot_pend = 1'b0;
					end else if (gpio_tog) begin
						next_state = mprs_pkg::MPRS_SAVE;
						next_detach_pend = 1'b0;
						next_reboot_pend = 1'b0;
					end else if (cmd.func_valid &&
							cmd.func_code == mprs_pkg::FUNC_REBOOT) begin
						next_state = mprs_pkg::MPRS_SAVE;
						next_detach_pend = 1'b1;
						next_reboot_pend = 1'b1;
					end else if (cmd.sleep_req) begin
						next_state = mprs_pkg::MPRS_SLEEP;
					end
				end else if (state == mprs_pkg::MPRS_SAVE) begin
					if (save_done) begin
						next_state = detach_pend ? mprs_pkg::MPRS_DETACH :
							(reboot_pend ? mprs_pkg::MPRS_REBOOT :
							mprs_pkg::MPRS_OFF);
					end
				end else if (state == mprs_pkg::MPRS_DETACH) begin
					if (detach_done) begin
						next_state = reboot_pend ? mprs_pkg::MPRS_REBOOT :
							mprs_pkg::MPRS_OFF;
					end
				end else begin
					next_state = mprs_pkg::MPRS_ON;
				end
			end
		endcase
		if (!supply_valid) begin
			next_state = mprs_pkg::MPRS_OFF;
		end
		next_stat.save_req = next_state == mprs_pkg::MPRS_SAVE;
		next_stat.detach_req = next_state == mprs_pkg::MPRS_DETACH;
		next_stat.core_on = next_state == mprs_pkg::MPRS_ON;
		next_stat.sleeping = next_state == mprs_pkg::MPRS_SLEEP;
		next_stat.v_int_en = next_state != mprs_pkg::MPRS_OFF &&
			next_state != mprs_pkg::MPRS_SLEEP;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= mprs_pkg::MPRS_OFF;
			detach_pend <= 1'b0;
			reboot_pend <= 1'b0;
			stat <= '0;
		end else begin
			state <= next_state;
			detach_pend <= next_detach_pend;
			reboot_pend <= next_reboot_pend;
			stat <= next_stat;
		end
	end
endmodule

// ### verif/mprs_props.sv
`timescale 1ns/10ps
module mprs_props (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic supply_valid,
	input wire logic reset_request_n,
	input wire mprs_pkg::mprs_cmd_s cmd,
	input wire mprs_pkg::mprs_stat_s stat,
	input wire mprs_pkg::mprs_state_e state
);
	// *****
	// Checks
	// *****
	// Higher-priority events are masked out so each check sees one cause.
	logic calm;
	logic on_ok;
	assign calm = supply_valid && reset_request_n &&
		!(cmd.temp_supervisor_cmd && cmd.temp_danger);
	assign on_ok = state == mprs_pkg::MPRS_ON && calm;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_graceful_save: assert property (on_ok &&
		cmd.graceful_poweroff_cmd |=> state == mprs_pkg::MPRS_SAVE)
		else $error("graceful off did not save");
	a_fast_save: assert property (on_ok && cmd.func_valid &&
		!cmd.graceful_poweroff_cmd && cmd.func_code == mprs_pkg::FUNC_FAST_OFF
		|=> state == mprs_pkg::MPRS_SAVE) else $error("fast off did not save");
	a_toggle_save: assert property (on_ok && !cmd.func_valid &&
		!cmd.graceful_poweroff_cmd && !$stable(cmd.fast_off_gpio)
		|=> state == mprs_pkg::MPRS_SAVE) else $error("toggle did not save");
	a_temp_off: assert property (state == mprs_pkg::MPRS_ON &&
		supply_valid && reset_request_n && cmd.temp_supervisor_cmd &&
		cmd.temp_danger |=> state == mprs_pkg::MPRS_OFF)
		else $error("danger did not shut down");
	a_supply_off: assert property (!supply_valid |=>
		state == mprs_pkg::MPRS_OFF) else $error("no supply but not off");
	a_vint_state: assert property (state inside {mprs_pkg::MPRS_ON,
		mprs_pkg::MPRS_OFF} |-> stat.v_int_en == (state == mprs_pkg::MPRS_ON))
		else $error("interface supply wrong");
	a_reboot_on: assert property (state == mprs_pkg::MPRS_REBOOT &&
		calm |=> state == mprs_pkg::MPRS_ON) else $error("reboot not one cycle");
	a_req_decode: assert property (stat.save_req ==
		(state == mprs_pkg::MPRS_SAVE) ##0 stat.detach_req ==
		(state == mprs_pkg::MPRS_DETACH)) else $error("request flags wrong");
	c_wake: cover property (state == mprs_pkg::MPRS_SLEEP ##1
		state == mprs_pkg::MPRS_ON);
	c_reboot: cover property (state == mprs_pkg::MPRS_REBOOT);
	c_detach: cover property (state == mprs_pkg::MPRS_DETACH);
endmodule

// ### verif/mprs_host.sv
`timescale 1ns/10ps
module mprs_host (
	input wire logic mclk,
	input wire mprs_pkg::mprs_stat_s stat,
	output logic switch_on_request_n,
	output logic reset_request_n,
	output logic save_done = 1'b0,
	output logic detach_done = 1'b0
);
	// *****
	// Host
	// *****
	logic on_low = 1'b0;
	logic rst_low = 1'b0;
	int dly = 1;
	int cnt = 0;
	// Lines are only pulled low; released they sit at the pull-up level.
	assign switch_on_request_n = on_low ? 1'b0 : 1'b1;
	assign reset_request_n = rst_low ? 1'b0 : 1'b1;
	always @(posedge mclk) begin
		cnt <= (save_done || detach_done) ? 0 :
			((stat.save_req || stat.detach_req) ? cnt + 1 : 0);
		save_done <= stat.save_req && cnt == dly && !save_done;
		detach_done <= stat.detach_req && cnt == dly && !detach_done;
	end
endmodule

// ### verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic supply_low = 1'b1;
	logic supply_valid = 1'b0;
	logic switch_on_request_n, reset_request_n, save_done, detach_done;
	mprs_pkg::mprs_cmd_s cmd = '0;
	mprs_pkg::mprs_stat_s stat;
	mprs_pkg::mprs_state_e state;
	int fail_count = 0;
	int checks = 0;
	logic [31:0] seed = 32'he0e7b9b3;
	logic [7:0] code;
	always #4 mclk = ~mclk;
	mprs_host i_mprs_host (.mclk, .stat, .switch_on_request_n,
		.reset_request_n, .save_done, .detach_done);
	mprs_sequencer #(.SWITCH_ON_CYC(6), .WAKE_CYC(6), .RESET_CYC(4),
		.RAMP_CYC(20)) i_mprs_sequencer (.mclk, .rst_n, .supply_low,
		.supply_valid, .switch_on_request_n, .reset_request_n, .cmd,
		.save_done, .detach_done, .stat, .state);
	// *****
	// Helpers
	// *****
	function automatic logic [31:0] lfsr(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic mprs_pkg::mprs_state_e after_code(logic [7:0] c);
		return (c == mprs_pkg::FUNC_FAST_OFF || c == mprs_pkg::FUNC_REBOOT) ?
			mprs_pkg::MPRS_SAVE : mprs_pkg::MPRS_ON;
	endfunction
	task automatic chk(mprs_pkg::mprs_state_e e);
		checks++;
		if (state !== e) begin
			fail_count++;
			$display("[ERR] %0t state %0d not %0d", $time, state, e);
		end
	endtask
	task automatic chk_b(logic g, logic e);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t status bit %b not %b", $time, g, e);
		end
	endtask
	task automatic await(mprs_pkg::mprs_state_e e);
		for (int i = 0; i < 60 && state !== e; i++) begin
			@(posedge mclk);
			#1;
		end
		chk(e);
	endtask
	// Released at the end, so a held switch-on pin is freed together.
	task automatic press(int n, bit r);
		@(posedge mclk);
		if (r) i_mprs_host.rst_low <= 1'b1;
		else i_mprs_host.on_low <= 1'b1;
		repeat (n) @(posedge mclk);
		i_mprs_host.rst_low <= 1'b0;
		i_mprs_host.on_low <= 1'b0;
		// Step off the edge so a one-cycle state is seen by the caller.
		#1;
	endtask
	task automatic test_done;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		test_done;
	end
	// *****
	// Scenarios
	// *****
	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		supply_valid <= 1'b1;
		supply_low <= 1'b0;
		await(mprs_pkg::MPRS_ON);
		chk_b(stat.v_int_en, 1'b1);
		chk_b(stat.core_on, 1'b1);
		i_mprs_host.dly = 3;
		@(posedge mclk) cmd.graceful_poweroff_cmd <= 1'b1;
		@(posedge mclk) cmd.graceful_poweroff_cmd <= 1'b0;
		#1 chk(mprs_pkg::MPRS_SAVE);
		await(mprs_pkg::MPRS_DETACH);
		await(mprs_pkg::MPRS_OFF);
		chk_b(stat.v_int_en, 1'b0);
		press(3, 0);
		repeat (4) @(posedge mclk);
		#1 chk(mprs_pkg::MPRS_OFF);
		press(6, 0);
		await(mprs_pkg::MPRS_ON);
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			i_mprs_host.dly = seed[9:8];
			code = k < 2 ? (k ? mprs_pkg::FUNC_REBOOT : mprs_pkg::FUNC_FAST_OFF)
				: seed[7:0];
			@(posedge mclk);
			cmd.func_code <= code;
			cmd.func_valid <= 1'b1;
			@(posedge mclk) cmd.func_valid <= 1'b0;
			#1 chk(after_code(code));
			await(code == mprs_pkg::FUNC_FAST_OFF ? mprs_pkg::MPRS_OFF
				: mprs_pkg::MPRS_ON);
			if (state === mprs_pkg::MPRS_OFF) begin
				press(6, 0);
				await(mprs_pkg::MPRS_ON);
			end
		end
		@(posedge mclk) cmd.fast_off_gpio <= ~cmd.fast_off_gpio;
		@(posedge mclk);
		#1 chk(mprs_pkg::MPRS_SAVE);
		await(mprs_pkg::MPRS_OFF);
		press(6, 0);
		await(mprs_pkg::MPRS_ON);
		@(posedge mclk) cmd.temp_danger <= 1'b1;
		repeat (2) @(posedge mclk);
		#1 chk(mprs_pkg::MPRS_ON);
		@(posedge mclk) cmd.temp_supervisor_cmd <= 1'b1;
		@(posedge mclk) cmd.temp_danger <= 1'b0;
		#1 chk(mprs_pkg::MPRS_OFF);
		press(6, 0);
		await(mprs_pkg::MPRS_ON);
		press(5, 1);
		await(mprs_pkg::MPRS_REBOOT);
		await(mprs_pkg::MPRS_ON);
		@(posedge mclk) cmd.sleep_req <= 1'b1;
		@(posedge mclk) cmd.sleep_req <= 1'b0;
		#1 chk(mprs_pkg::MPRS_SLEEP);
		chk_b(stat.sleeping, 1'b1);
		chk_b(stat.v_int_en, 1'b0);
		press(7, 0);
		await(mprs_pkg::MPRS_ON);
		@(posedge mclk) i_mprs_host.on_low <= 1'b1;
		repeat (8) @(posedge mclk);
		press(6, 1);
		await(mprs_pkg::MPRS_OFF);
		press(6, 0);
		await(mprs_pkg::MPRS_ON);
		@(posedge mclk) supply_valid <= 1'b0;
		@(posedge mclk);
		#1 chk(mprs_pkg::MPRS_OFF);
		test_done;
	end
endmodule
bind mprs_sequencer mprs_props i_mprs_props (.mclk, .rst_n, .supply_valid,
	.reset_request_n, .cmd, .stat, .state);
